/* tcc_defines.svh */
// Address, bit position, reset and sizing constants of the terminal channel controller
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH

// ----------------------------------------------------------------
// Channel addresses
// ----------------------------------------------------------------
`define TCC_ADDR_DATA       16'h0090
`define TCC_ADDR_FUNC       16'h0091

// ----------------------------------------------------------------
// Function word bit positions
// ----------------------------------------------------------------
`define TCC_FN_CLR_CTL      0
`define TCC_FN_CLR_INT      1
`define TCC_FN_ARM_DATA     2
`define TCC_FN_ARM_EOP      3
`define TCC_FN_ARM_ALARM    4
`define TCC_FN_SEL_WRITE    8
`define TCC_FN_SEL_READ     9
`define TCC_FN_ECHO_ON      10
`define TCC_FN_ECHO_OFF     13

// ----------------------------------------------------------------
// Status word bit positions and fixed pattern
// ----------------------------------------------------------------
`define TCC_ST_BUSY         1
`define TCC_ST_INT          2
`define TCC_ST_DATA         3
`define TCC_ST_EOP          4
`define TCC_ST_ALARM        5
`define TCC_ST_LOST         6
`define TCC_ST_PARITY       7
`define TCC_ST_READ_MODE    9
`define TCC_ST_MANUAL       11
`define TCC_ST_FIXED        16'h0401

// ----------------------------------------------------------------
// Reset values and buffer sizing
// ----------------------------------------------------------------
`define TCC_RST_READ_MODE   1'b1
`define TCC_FIFO_WIDTH      8
`define TCC_FIFO_DEPTH      32

`endif

/* tcc_pkg.sv */
// Types shared by the terminal channel controller
package tcc_pkg;

  // ----------------------------------------------------------------
  // Channel request and answer
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        rd;       // Input to accumulator strobe
    logic        wr;       // Output from accumulator strobe
    logic [15:0] addr;     // Q register address
    logic [15:0] a;        // Accumulator contents on output
  } tcc_io_req_s;

  typedef struct packed {
    logic        reply;      // Operation performed
    logic        reject;     // Operation refused
    logic        char_input; // Only low eight bits valid
    logic [15:0] data;       // Status or character
  } tcc_io_rsp_s;

  // ----------------------------------------------------------------
  // Terminal character streams
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       valid;     // Character strobe
    logic [7:0] chr;       // Character with parity in bit 7
  } tcc_char_s;

  // ----------------------------------------------------------------
  // Controller state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        read_mode;  // Read mode selected
    logic [7:0]  hold;       // Receive hold register
    logic        hold_full;  // Hold register has a character
    logic        lost;       // Lost data
    logic        parity;     // Parity error
    logic        manual;     // Manual interrupt
    logic        arm_data;   // Data interrupt armed
    logic        arm_eop;    // End of operation interrupt armed
    logic        arm_alarm;  // Alarm interrupt armed
    logic        echo_off;   // Printer echo suppressed
    logic        int_lvl1;   // Interrupt on level one
    tcc_io_rsp_s rsp;        // Channel answer
  } tcc_state_s;

endpackage : tcc_pkg

/* tcc_ctrl.sv */
// Terminal channel controller: output FIFO and the controller top level
`include "tcc_defines.svh"

// ----------------------------------------------------------------
// Output character FIFO
// ----------------------------------------------------------------
module tcc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             i_clk_sys,
  input  wire logic             i_arst_n,
  // Control
  input  wire logic             i_flush,
  // Fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // Drain side
  output logic                  o_out_valid,
  output logic      [WIDTH-1:0] o_out_data,
  input  wire logic             i_out_ready
);

  localparam int AW = $clog2(DEPTH);

  // All FIFO state in one record
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;       // Storage
    logic [AW-1:0]               wr_ptr;    // Write index
    logic [AW-1:0]               rd_ptr;    // Read index
    logic [AW:0]                 count;     // Occupancy
    logic                        not_empty; // Registered valid
    logic                        not_full;  // Registered ready
  } tcc_fifo_st_s;

  tcc_fifo_st_s st_q;  // Current state
  tcc_fifo_st_s st_d;  // Next state
  logic         push;  // Accepted write
  logic         pop;   // Accepted read

  // Handshakes use the registered flags, so full and empty are exact
  assign push        = i_in_valid & st_q.not_full;
  assign pop         = i_out_ready & st_q.not_empty;
  assign o_in_ready  = st_q.not_full;
  assign o_out_valid = st_q.not_empty;
  assign o_out_data  = st_q.mem[st_q.rd_ptr];

  // Next state
  always_comb begin
    st_d = st_q;
    if (i_flush) begin
      // Flush drops everything, even a push in the same cycle
      st_d.wr_ptr = '0;
      st_d.rd_ptr = '0;
      st_d.count  = '0;
    end else begin
      if (push) begin
        st_d.mem[st_q.wr_ptr] = i_in_data;
        st_d.wr_ptr           = AW'(st_q.wr_ptr + 1'b1);
      end
      if (pop) begin
        st_d.rd_ptr = AW'(st_q.rd_ptr + 1'b1);
      end
      if (push & ~pop) begin
        st_d.count = (AW+1)'(st_q.count + 1'b1);
      end else if (pop & ~push) begin
        st_d.count = (AW+1)'(st_q.count - 1'b1);
      end
    end
    st_d.not_empty = (st_d.count != '0);
    st_d.not_full  = (st_d.count != (AW+1)'(DEPTH));
  end

  // State register
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q          <= '0;
      st_q.not_full <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

endmodule // tcc_fifo

// Function
// R01: Decode 0091 function/status, 0090 data only
// R02: Data input fills low eight bits only
// R03: Data output sends low eight bits
// R04: Clear controller resets state, read mode, echo
// R05: Clear interrupt drops requests and manual
// R06: Bit A2 arms data interrupt
// R07: Bit A3 arms end-of-operation interrupt
// R08: Bit A4 arms alarm; A5 written zero
// R09: A8 write mode clears lost; A9 read
// R10: A13 suppresses echo, A10 restores it
// R11: Do what is possible; reject if nothing
// R12: Status fixed bits 0,10 one; 8,12-15 zero
// R13: Busy while character held or sending
// R14: Data status shows transfer possible
// R15: End of operation is inverse busy
// R16: Alarm equals lost data or parity
// R17: Overrun sets lost data, locks input
// R18: Bad received parity sets parity error
// R19: Status shows interrupt and read mode
// R20: Manual interrupt sticky until cleared
// R21: Data interrupt follows transfer possibility
// R22: Arming alarm with alarm pending interrupts
// R23: Status read always replied
// R24: Interrupt level one from armed conditions
// R25: Impossible data transfers are rejected
module tcc_ctrl (
  // Clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_arst_n,
  // Processor channel
  input  wire tcc_pkg::tcc_io_req_s i_io,
  output tcc_pkg::tcc_io_rsp_s   o_io,
  output logic                   o_int_lvl1,
  // Terminal receive side
  input  wire tcc_pkg::tcc_char_s i_rx,
  input  wire logic              i_manual_int,
  output logic                   o_rx_lockout,
  output logic                   o_echo_en,
  // Terminal transmit side
  output tcc_pkg::tcc_char_s     o_tx,
  input  wire logic              i_tx_ready
);
  import tcc_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  tcc_state_s st_q;       // Current state
  tcc_state_s st_d;       // Next state
  logic       sel_data;   // Data address hit
  logic       sel_func;   // Function/status address hit
  logic       busy;       // Busy status
  logic       data_ok;    // Data status
  logic       push;       // Character into FIFO
  logic       flush;      // FIFO cleared by controller clear
  logic       fifo_ready; // FIFO can take a character
  logic       fifo_valid; // FIFO holds a character
  logic [7:0] fifo_data;  // FIFO head
  logic       do_mode;    // Mode selection performed
  logic       other_fn;   // Some always-performed function present

  // Even parity over all eight bits; odd count is an error
  function automatic logic parity_bad(input logic [7:0] c);
    parity_bad = ^c;
  endfunction

  // Assemble the status word from state and derived conditions
  function automatic logic [15:0] status_word(input tcc_state_s s, input logic b, input logic d);
    logic [15:0] w;
    w                    = `TCC_ST_FIXED;
    w[`TCC_ST_BUSY]      = b;
    w[`TCC_ST_INT]       = s.int_lvl1;
    w[`TCC_ST_DATA]      = d;
    // R15 inverse of busy
    w[`TCC_ST_EOP]       = ~b;
    // R16 lost or parity
    w[`TCC_ST_ALARM]     = s.lost | s.parity;
    w[`TCC_ST_LOST]      = s.lost;
    w[`TCC_ST_PARITY]    = s.parity;
    w[`TCC_ST_READ_MODE] = s.read_mode;
    w[`TCC_ST_MANUAL]    = s.manual;
    status_word = w;
  endfunction

  // ----------------------------------------------------------------
  // Output buffer toward the terminal
  // ----------------------------------------------------------------
  // Lets software run ahead of a slow terminal; the terminal's ready stalls it
  tcc_fifo #(
    .WIDTH (`TCC_FIFO_WIDTH),
    .DEPTH (`TCC_FIFO_DEPTH)
  ) u_fifo (
    .i_clk_sys   (i_clk_sys),
    .i_arst_n    (i_arst_n),
    .i_flush     (flush),
    .i_in_valid  (push),
    .i_in_data   (i_io.a[7:0]),
    .o_in_ready  (fifo_ready),
    .o_out_valid (fifo_valid),
    .o_out_data  (fifo_data),
    .i_out_ready (i_tx_ready)
  );

  // ----------------------------------------------------------------
  // Decode and derived status
  // ----------------------------------------------------------------
  // R01 address decode
  assign sel_data = (i_io.addr == `TCC_ADDR_DATA);
  assign sel_func = (i_io.addr == `TCC_ADDR_FUNC);
  // R13 busy per mode
  assign busy     = st_q.read_mode ? st_q.hold_full : fifo_valid;
  // R14 data per mode
  assign data_ok  = st_q.read_mode ? st_q.hold_full : fifo_ready;
  // R09 mode refused while busy
  assign do_mode  = (i_io.a[`TCC_FN_SEL_WRITE] | i_io.a[`TCC_FN_SEL_READ]) & ~busy;
  assign other_fn = i_io.a[`TCC_FN_CLR_CTL] | i_io.a[`TCC_FN_CLR_INT] | i_io.a[`TCC_FN_ARM_DATA]
                  | i_io.a[`TCC_FN_ARM_EOP] | i_io.a[`TCC_FN_ARM_ALARM]
                  | i_io.a[`TCC_FN_ECHO_ON] | i_io.a[`TCC_FN_ECHO_OFF];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d                = st_q;
    st_d.rsp            = '0;  // Answer is a one-cycle pulse
    push                = 1'b0;
    flush               = 1'b0;
    // Status read
    if (i_io.rd & sel_func) begin
      // R23 status never refused
      st_d.rsp.reply = 1'b1;
      // R12 fixed status bits
      // R19 interrupt and mode bits
      st_d.rsp.data  = status_word(st_q, busy, data_ok);
    end
    // Data read
    if (i_io.rd & sel_data) begin
      if (st_q.read_mode & st_q.hold_full) begin
        // R02 low byte, upper bits zeroed
        st_d.rsp.reply      = 1'b1;
        st_d.rsp.char_input = 1'b1;
        st_d.rsp.data       = {8'h00, st_q.hold};
        st_d.hold_full      = 1'b0;
      end else begin
        // R25 nothing held
        st_d.rsp.reject = 1'b1;
      end
    end
    // Data write
    if (i_io.wr & sel_data) begin
      if (~st_q.read_mode & fifo_ready) begin
        // R03 low byte to terminal
        push           = 1'b1;
        st_d.rsp.reply = 1'b1;
      end else begin
        // R25 wrong mode or no room
        st_d.rsp.reject = 1'b1;
      end
    end
    // Function word
    if (i_io.wr & sel_func) begin
      // R11 partial execution, reject if none
      if (other_fn | do_mode | ~(i_io.a[`TCC_FN_SEL_WRITE] | i_io.a[`TCC_FN_SEL_READ])) begin
        st_d.rsp.reply = 1'b1;
      end else begin
        st_d.rsp.reject = 1'b1;
      end
      if (i_io.a[`TCC_FN_CLR_CTL]) begin
        // R04 controller clear
        st_d.arm_data  = 1'b0;
        st_d.arm_eop   = 1'b0;
        st_d.arm_alarm = 1'b0;
        st_d.hold_full = 1'b0;
        st_d.lost      = 1'b0;
        st_d.parity    = 1'b0;
        st_d.read_mode = 1'b1;
        st_d.echo_off  = 1'b0;
        // R20 manual interrupt dropped too
        st_d.manual    = 1'b0;
        flush          = 1'b1;
      end
      if (i_io.a[`TCC_FN_CLR_INT]) begin
        // R05 interrupt clear
        st_d.arm_data  = 1'b0;
        st_d.arm_eop   = 1'b0;
        st_d.arm_alarm = 1'b0;
        st_d.manual    = 1'b0;
      end
      // R06 arm data, after clears so it wins
      if (i_io.a[`TCC_FN_ARM_DATA]) begin
        st_d.arm_data = 1'b1;
      end
      // R07 arm end of operation
      if (i_io.a[`TCC_FN_ARM_EOP]) begin
        st_d.arm_eop = 1'b1;
      end
      // R08 arm alarm; A5 carries no function
      if (i_io.a[`TCC_FN_ARM_ALARM]) begin
        st_d.arm_alarm = 1'b1;
      end
      // R10 echo control, reconnect wins a conflict
      if (i_io.a[`TCC_FN_ECHO_OFF]) begin
        st_d.echo_off = 1'b1;
      end
      if (i_io.a[`TCC_FN_ECHO_ON]) begin
        st_d.echo_off = 1'b0;
      end
      // R09 mode change only when not busy
      // R09 read wins if both selected
      if (do_mode) begin
        if (i_io.a[`TCC_FN_SEL_READ]) begin
          st_d.read_mode = 1'b1;
        end else begin
          st_d.read_mode = 1'b0;
          st_d.lost      = 1'b0;
        end
      end
    end
    // Terminal character arrives; placed after clears so the set wins
    if (i_rx.valid & st_d.read_mode & ~st_d.lost) begin
      if (st_d.hold_full) begin
        // R17 overrun, character dropped
        st_d.lost = 1'b1;
      end else begin
        st_d.hold      = i_rx.chr;
        st_d.hold_full = 1'b1;
        // R18 parity check
        if (parity_bad(i_rx.chr)) begin
          st_d.parity = 1'b1;
        end
      end
    end
    // R20 manual interrupt is sticky, set beats clear
    if (i_manual_int) begin
      st_d.manual = 1'b1;
    end
    // R21 data interrupt tracks transfer possibility
    // R22 pending alarm fires once armed
    // R24 level one interrupt
    st_d.int_lvl1 = (st_q.arm_data & data_ok) | (st_q.arm_eop & ~busy)
                  | (st_q.arm_alarm & (st_q.lost | st_q.parity)) | st_q.manual;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q           <= '0;
      st_q.read_mode <= `TCC_RST_READ_MODE;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_io         = st_q.rsp;
  assign o_int_lvl1   = st_q.int_lvl1;
  // R17 input lockout
  assign o_rx_lockout = st_q.lost;
  assign o_echo_en    = ~st_q.echo_off;
  assign o_tx.valid   = fifo_valid;
  assign o_tx.chr     = fifo_data;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  a_addr_ignore: assert property ((i_io.rd | i_io.wr) & ~sel_data & ~sel_func // R01
    |=> !o_io.reply && !o_io.reject) else $error("Unmapped address answered");

  a_read_char: assert property (i_io.rd & sel_data & st_q.read_mode & st_q.hold_full & ~i_rx.valid // R02
    |=> o_io.reply && o_io.char_input && o_io.data == {8'h00, $past(st_q.hold)} && !st_q.hold_full)
    else $error("Data input answer wrong");

  a_write_char: assert property (i_io.wr & sel_data & ~st_q.read_mode & fifo_ready // R03
    |-> push ##1 o_io.reply) else $error("Data output not taken");

  a_clr_ctl: assert property (i_io.wr & sel_func & i_io.a[`TCC_FN_CLR_CTL] & ~i_io.a[`TCC_FN_SEL_WRITE] // R04
    & ~i_rx.valid & ~i_manual_int |=> st_q.read_mode && !st_q.lost && !st_q.hold_full && !st_q.manual
        && o_echo_en == !($past(i_io.a[13]) & !$past(i_io.a[10])))
    else $error("Controller clear incomplete");

  a_clr_int: assert property (i_io.wr & sel_func & i_io.a[`TCC_FN_CLR_INT] & ~i_manual_int // R05
    |=> !st_q.manual && st_q.arm_data == $past(i_io.a[2])) else $error("Interrupt clear failed");

  a_arm_bits: assert property (i_io.wr & sel_func // R06
    |=> st_q.arm_data == ($past(i_io.a[2]) | ($past(st_q.arm_data) & !$past(i_io.a[0]) & !$past(i_io.a[1]))))
    else $error("Data arm wrong");

  a_mode_busy: assert property (i_io.wr & sel_func & busy & ~i_io.a[`TCC_FN_CLR_CTL] // R09
    |=> $stable(st_q.read_mode)) else $error("Mode changed while busy");

  a_reject_all: assert property (i_io.wr & sel_func & busy & ~other_fn // R11
    & (i_io.a[`TCC_FN_SEL_WRITE] | i_io.a[`TCC_FN_SEL_READ]) |=> o_io.reject && !o_io.reply)
    else $error("Refused function word not rejected");

  a_status_word: assert property (i_io.rd & sel_func // R12
    |=> o_io.reply && o_io.data[0] && o_io.data[10] && !o_io.data[8] && o_io.data[15:12] == 4'h0
        && o_io.data[4] == !o_io.data[1] && o_io.data[5] == (o_io.data[6] | o_io.data[7]))
    else $error("Status word pattern wrong");

  a_lost_set: assert property (i_rx.valid & st_q.read_mode & st_q.hold_full & ~st_q.lost // R17
    & ~i_io.rd & ~i_io.wr |=> st_q.lost && o_rx_lockout) else $error("Overrun not flagged");

  a_alarm_int: assert property (st_q.arm_alarm & (st_q.lost | st_q.parity) // R22
    |=> o_int_lvl1) else $error("Armed alarm did not interrupt");

  a_manual_int: assert property ($rose(st_q.manual) // R24
    |=> o_int_lvl1) else $error("Manual interrupt missed");

  a_bad_read: assert property (i_io.rd & sel_data & ~(st_q.read_mode & st_q.hold_full) // R25
    |=> o_io.reject && !o_io.reply && !o_io.char_input) else $error("Impossible read not rejected");

  c_read_char: cover property (i_io.rd & sel_data ##1 o_io.reply);
  c_write_full: cover property (~st_q.read_mode & ~fifo_ready ##1 i_io.wr & sel_data);
  c_fn_reject: cover property (i_io.wr & sel_func ##1 o_io.reject);
  c_lost_data: cover property ($rose(st_q.lost));

endmodule // tcc_ctrl

/* tcc_term_model.sv */
// Behavioural terminal on the far side of the terminal channel controller
module tcc_term_model (
  // Clock
  input  wire logic                i_clk_sys,
  // Characters from the controller
  input  wire tcc_pkg::tcc_char_s  i_tx,
  output logic                     o_tx_ready,
  // Characters toward the controller
  output tcc_pkg::tcc_char_s       o_rx,
  input  wire logic                i_rx_lockout,
  input  wire logic                i_echo_en
);
  timeunit 1ns;
  timeprecision 100ps;
  import tcc_pkg::*;

  // ----------------------------------------------------------------
  // Model state
  // ----------------------------------------------------------------
  logic       stall;    // Printer holds off when set
  logic [7:0] got_q[$]; // Characters printed, in order
  int         echo_cnt; // Keyed characters echoed to the printer

  initial begin
    stall = 1'b0;
    echo_cnt = 0;
    o_rx  = '{valid: 1'b0, chr: 8'h00};
  end

  // Printer side takes the head whenever not stalled
  assign o_tx_ready = ~stall;

  // Collect every character popped from the controller
  always @(posedge i_clk_sys) begin
    if (i_tx.valid === 1'b1 && o_tx_ready === 1'b1) begin
      got_q.push_back(i_tx.chr);
    end
  end

  // One keyed character; a locked keyboard sends nothing
  task automatic send(input logic [7:0] c);
    if (i_rx_lockout !== 1'b1) begin
      o_rx.valid = 1'b1;
      o_rx.chr   = c;
      // Echo return prints the keyed character
      if (i_echo_en === 1'b1) begin
        echo_cnt++;
      end
      @(negedge i_clk_sys);
      o_rx.valid = 1'b0;
      // Idle line shows the inverse so a stale value never looks valid
      o_rx.chr   = ~c;
    end
  endtask
endmodule // tcc_term_model

/* test_terminal_channel_controller.sv */
// Self-checking testbench of the terminal channel controller
module test_terminal_channel_controller;
  timeunit 1ns;
  timeprecision 100ps;
  import tcc_pkg::*;
  `include "tcc_defines.svh"

  // ----------------------------------------------------------------
  // Signals and counters
  // ----------------------------------------------------------------
  logic        clk;          // 200 MHz system clock
  logic        arst_n;       // Async reset, active low
  tcc_io_req_s io_req;       // Channel request
  tcc_io_rsp_s io_rsp;       // Channel answer
  logic        int_lvl1;     // Interrupt level one
  tcc_char_s   rx;           // From terminal
  tcc_char_s   tx;           // To terminal
  logic        tx_ready;     // Terminal accepts
  logic        manual_int;   // Manual interrupt event
  logic        rx_lockout;   // Keyboard lockout
  logic        echo_en;      // Printer echo
  int          err_count;    // Mismatches
  int          checks_done;  // Comparisons made

  // ----------------------------------------------------------------
  // Clock, design and terminal
  // ----------------------------------------------------------------
  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  tcc_ctrl u_dut (
    .i_clk_sys(clk), .i_arst_n(arst_n), .i_io(io_req), .o_io(io_rsp), .o_int_lvl1(int_lvl1),
    .i_rx(rx), .i_manual_int(manual_int), .o_rx_lockout(rx_lockout), .o_echo_en(echo_en),
    .o_tx(tx), .i_tx_ready(tx_ready)
  );

  tcc_term_model u_term (
    .i_clk_sys(clk), .i_tx(tx), .o_tx_ready(tx_ready), .o_rx(rx),
    .i_rx_lockout(rx_lockout), .i_echo_en(echo_en)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Verdict and end of run; also reached when a bounded wait runs out
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One channel cycle: strobe for one clock, then watch a short window
  task automatic io(input logic wr, input logic [15:0] addr, input logic [15:0] a,
                    output logic [2:0] rr, output logic [15:0] d);
    int n;
    rr = 3'b000;
    d  = 16'h0000;
    // Let the previous strobe's low level reach an edge first
    @(negedge clk);
    io_req = '{rd: ~wr, wr: wr, addr: addr, a: a};
    @(negedge clk);
    io_req.rd = 1'b0;
    io_req.wr = 1'b0;
    for (n = 0; n < 3; n++) begin
      if (io_rsp.reply === 1'b1 || io_rsp.reject === 1'b1) begin
        rr = {io_rsp.reply, io_rsp.reject, io_rsp.char_input};
        d  = io_rsp.data;
        break;
      end
      @(negedge clk);
    end
  endtask

  // Expected answer codes: {reply, reject, char_input}
  task automatic st(input logic [15:0] exp);
    logic [2:0] rr;
    logic [15:0] d;
    io(1'b0, `TCC_ADDR_FUNC, 16'h0000, rr, d);
    chk("status answer", {13'h0000, rr}, 16'h0004);
    chk("status word", d, exp);
  endtask

  task automatic fn(input logic [15:0] w, input logic [2:0] exp_rr);
    logic [2:0] rr;
    logic [15:0] d;
    io(1'b1, `TCC_ADDR_FUNC, w, rr, d);
    chk("function answer", {13'h0000, rr}, {13'h0000, exp_rr});
  endtask

  task automatic xfer(input logic wr, input logic [15:0] a, input logic [2:0] exp_rr,
                      input logic [15:0] exp_d);
    logic [2:0] rr;
    logic [15:0] d;
    io(wr, `TCC_ADDR_DATA, a, rr, d);
    chk("data answer", {13'h0000, rr}, {13'h0000, exp_rr});
    chk("data value", d, exp_d);
  endtask

  task automatic lvl(input logic exp);
    repeat (2) @(negedge clk);
    chk("interrupt", {15'h0000, int_lvl1}, {15'h0000, exp});
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [2:0] rr;
    logic [15:0] d;
    int n;
    err_count = 0;
    checks_done = 0;
    arst_n = 1'b0;
    manual_int = 1'b0;
    io_req = '{rd: 1'b0, wr: 1'b0, addr: 16'h0000, a: 16'h0000};
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    // Idle after reset: read mode, not busy
    st(16'h0611);
    chk("echo", {15'h0000, echo_en}, 16'h0001);
    xfer(1'b0, 16'h0000, 3'b010, 16'h0000);
    io(1'b0, 16'h0092, 16'h0000, rr, d);
    chk("unmapped", {13'h0000, rr}, 16'h0000);
    // Overrun then alarm armed late
    u_term.send(8'h41);
    st(16'h060B);
    u_term.send(8'h42);
    st(16'h066B);
    chk("lockout", {15'h0000, rx_lockout}, 16'h0001);
    fn(16'h0010, 3'b100);
    lvl(1'b1);
    st(16'h066F);
    fn(16'h0001, 3'b100);
    lvl(1'b0);
    st(16'h0611);
    chk("lockout", {15'h0000, rx_lockout}, 16'h0000);
    // Bad parity received
    u_term.send(8'h43);
    st(16'h06AB);
    xfer(1'b0, 16'h0000, 3'b101, 16'h0043);
    st(16'h06B1);
    fn(16'h0001, 3'b100);
    // Data interrupt follows a held character
    fn(16'h0004, 3'b100);
    u_term.send(8'h41);
    lvl(1'b1);
    st(16'h060F);
    xfer(1'b0, 16'h0000, 3'b101, 16'h0041);
    lvl(1'b0);
    fn(16'h0002, 3'b100);
    // Manual interrupt is sticky until cleared
    @(negedge clk);
    manual_int = 1'b1;
    @(negedge clk);
    manual_int = 1'b0;
    lvl(1'b1);
    st(16'h0E15);
    fn(16'h0002, 3'b100);
    lvl(1'b0);
    st(16'h0611);
    manual_int = 1'b1;
    @(negedge clk);
    manual_int = 1'b0;
    fn(16'h0001, 3'b100);
    st(16'h0611);
    // Echo off and back on
    fn(16'h2000, 3'b100);
    chk("echo", {15'h0000, echo_en}, 16'h0000);
    fn(16'h0400, 3'b100);
    chk("echo", {15'h0000, echo_en}, 16'h0001);
    chk("echo count", 16'(u_term.echo_cnt), 16'h0004);
    // Write mode: fill the buffer while the printer stalls
    xfer(1'b1, 16'h5A00, 3'b010, 16'h0000);
    u_term.stall = 1'b1;
    fn(16'h0100, 3'b100);
    st(16'h0419);
    for (n = 0; n < `TCC_FIFO_DEPTH; n++) begin
      xfer(1'b1, {8'hA5, 8'(n)}, 3'b100, 16'h0000);
    end
    xfer(1'b1, 16'hA5FF, 3'b010, 16'h0000);
    st(16'h0403);
    fn(16'h0200, 3'b010);
    fn(16'h0204, 3'b100);
    st(16'h0403);
    u_term.stall = 1'b0;
    for (n = 0; n < 200 && tx.valid !== 1'b0; n++) begin
      @(negedge clk);
    end
    if (n == 200) begin
      err_count++;
      wrap_up();
    end
    chk("printed count", 16'(u_term.got_q.size()), 16'(`TCC_FIFO_DEPTH));
    foreach (u_term.got_q[i]) begin
      chk("printed char", {8'h00, u_term.got_q[i]}, {8'h00, 8'(i)});
    end
    lvl(1'b1);
    st(16'h041D);
    fn(16'h0001, 3'b100);
    st(16'h0611);
    wrap_up();
  end
endmodule // test_terminal_channel_controller
